//--- verilog/ctc_pkg.sv
package ctc_pkg;
    localparam int unsigned ADR_W = 12;
    localparam int unsigned DAT_W = 32;
    localparam int unsigned REG_W = 16;
    // Word indices; byte address is four times the index
    localparam logic [9:0] CONT_IDX  = 10'h10d;
    localparam logic [9:0] PCTL_IDX  = 10'h10e;
    localparam logic [9:0] SIZE_IDX  = 10'h10f;
    localparam logic [9:0] MERR_IDX  = 10'h110;
    localparam logic [9:0] IOCTL_IDX = 10'h111;
    // Command and flag positions; B_RES, B_LINK and B_CK in the program word only, bank field in the I/O word only
    localparam int unsigned B_SAVE = 0;
    localparam int unsigned B_LOAD = 1;
    localparam int unsigned B_CMP  = 2;
    localparam int unsigned B_RES  = 3;
    localparam int unsigned B_LINK = 11;
    localparam int unsigned B_MODE = 12;
    localparam int unsigned B_RO   = 13;
    localparam int unsigned B_CAP  = 14;
    localparam int unsigned B_CK   = 15;
    localparam int unsigned BANK_LO = 8;
    localparam int unsigned BANK_HI = 11;
    // Memory error word positions
    localparam int unsigned ME_SETUP = 11;
    localparam int unsigned ME_LAD   = 12;
    localparam int unsigned ME_VEC   = 13;
    localparam int unsigned ME_REM   = 14;
    localparam int unsigned ME_BOOT  = 15;
    // Software-writable bits
    localparam logic [15:0] PCTL_WMASK  = 16'hf807;
    localparam logic [15:0] IOCTL_WMASK = 16'h7007;
    localparam logic [15:0] REG_RST     = 16'h0000;
    // Operating modes
    localparam logic [1:0] MODE_PROG = 2'h0;
    localparam logic [1:0] MODE_RUN  = 2'h1;
    localparam logic [1:0] MODE_MON  = 2'h2;
    // Cassette contents codes
    localparam logic [1:0] CONT_NONE = 2'h0;
    localparam logic [1:0] CONT_PROG  = 2'h1;
    localparam logic [1:0] CONT_IODAT = 2'h2;
    // Transfer operations
    localparam logic [2:0] OP_PSAVE = 3'h0;
    localparam logic [2:0] OP_PLOAD = 3'h1;
    localparam logic [2:0] OP_PCMP  = 3'h2;
    localparam logic [2:0] OP_ISAVE = 3'h3;
    localparam logic [2:0] OP_ILOAD = 3'h4;
    typedef enum logic {CTC_IDLE, CTC_BUSY} ctc_state_t;
endpackage

//--- verilog/ctc_top.sv
// Our own choice: register access over Wishbone.
`timescale 1ns/10ps
// Function
// - Program save in programming mode copies program memory to cassette.
// - Program command bits clear themselves once acted on.
// - Program commands outside programming mode raise error, no transfer.
// - Program load copies cassette program in, programming mode only.
// - Program compare checks user memory against cassette.
// - Compare result 0 on match, 1 on difference or impossible compare.
// - Save while link table active sets link error flag.
// - Mode, read-only, capacity errors on bits 12, 13, 14.
// - Any program error except checksum blocks the save.
// - Cassette checksum failure sets bit 15; software repeats transfer.
// - Memory error word carries no cassette checksum detail.
// - Size word low byte gives cassette program size code.
// - Size code 00 means no ladder program stored.
// - Size word high byte gives CPU program size, same coding.
// - Memory error bits 11 to 15 flag setup, ladder, vector, removal, boot.
// - I/O save in programming mode copies I/O data memory to cassette.
// - I/O load copies cassette I/O data back into memory.
// - I/O commands outside programming mode raise error, no transfer.
// - I/O command bits clear themselves once handled.
// - Bank field shows extended data memory bank when cassette holds I/O.
// - I/O mode, read-only, capacity errors; read-only still transfers.
// - Contents type reported: 00 none, 01 program, 02 I/O data.
module ctc_top
    import ctc_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [DAT_W-1:0] wb_dat_i,
    output logic      [DAT_W-1:0] wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic [1:0]       ctl_mode,
    input  wire logic             link_table_active,
    input  wire logic             cart_read_only,
    input  wire logic             cart_space_ok,
    input  wire logic [1:0]       cart_contents,
    input  wire logic [3:0]       cart_bank,
    input  wire logic [7:0]       cart_prog_size,
    input  wire logic [7:0]       cpu_prog_size,
    input  wire logic             err_setup_cksum,
    input  wire logic             err_ladder_cksum,
    input  wire logic             err_vector_cksum,
    input  wire logic             err_cart_removed,
    input  wire logic             err_autoboot,
    output logic                  xfer_req,
    output logic      [2:0]       xfer_op,
    input  wire logic             xfer_done,
    input  wire logic             xfer_mismatch,
    input  wire logic             xfer_cksum_err
);

    function automatic logic [15:0] wmerge(
        input logic [15:0] old_v,
        input logic [15:0] new_v,
        input logic [1:0]  sel,
        input logic [15:0] mask
    );
        logic [15:0] m;
        m = {{8{sel[1]}}, {8{sel[0]}}} & mask;
        wmerge = (old_v & ~m) | (new_v & m);
    endfunction

    function automatic logic hit(
        input logic [ADR_W-1:0] adr,
        input logic [9:0]       idx
    );
        hit = (adr[ADR_W-1:2] == idx);
    endfunction

    ctc_state_t       st_reg;
    ctc_state_t       st_next;
    logic [15:0]      pctl_reg;
    logic [15:0]      pctl_next;
    logic [15:0]      ioctl_reg;
    logic [15:0]      ioctl_next;
    logic [15:0]      size_reg;
    logic [15:0]      size_next;
    logic [15:0]      merr_reg;
    logic [15:0]      merr_next;
    logic [1:0]       cont_reg;
    logic [1:0]       cont_next;
    logic             req_reg;
    logic             req_next;
    logic [2:0]       op_reg;
    logic [2:0]       op_next;
    logic             ack_reg;
    logic             ack_next;
    logic [DAT_W-1:0] dat_reg;
    logic [DAT_W-1:0] dat_next;
    logic             bus_req;
    logic             bus_wr;
    logic             prog_mode;
    logic             prog_cmd;
    logic             io_cmd;

    assign bus_req   = wb_cyc_i && wb_stb_i && !ack_reg;
    assign bus_wr    = bus_req && wb_we_i;
    assign prog_mode = (ctl_mode == MODE_PROG);
    assign prog_cmd  = |pctl_reg[B_CMP:B_SAVE];
    assign io_cmd    = |ioctl_reg[B_LOAD:B_SAVE];

    // Bus slave: every access answers one cycle after it is seen
    always_comb
    begin
        ack_next = bus_req;
        dat_next = dat_reg;
        if (bus_req && !wb_we_i)
        begin
            dat_next = '0;
            if (hit(wb_adr_i, CONT_IDX))
                dat_next[1:0] = cont_reg;
            else if (hit(wb_adr_i, PCTL_IDX))
                dat_next[15:0] = pctl_reg;
            else if (hit(wb_adr_i, SIZE_IDX))
                dat_next[15:0] = size_reg;
            else if (hit(wb_adr_i, MERR_IDX))
                dat_next[15:0] = merr_reg;
            else if (hit(wb_adr_i, IOCTL_IDX))
                dat_next[15:0] = ioctl_reg;
        end
    end

    // Status mirrors
    always_comb
    begin
        // Cassette fills the low byte, CPU the high byte
        size_next = {cpu_prog_size, cart_prog_size};
        cont_next = cart_contents;
        merr_next = REG_RST;
        // Only five flags live here; cassette checksum stays out
        merr_next[ME_SETUP] = err_setup_cksum;
        merr_next[ME_LAD]   = err_ladder_cksum;
        merr_next[ME_VEC]   = err_vector_cksum;
        merr_next[ME_REM]   = err_cart_removed;
        merr_next[ME_BOOT]  = err_autoboot;
    end

    // Command sequencer
    always_comb
    begin
        st_next    = st_reg;
        req_next   = req_reg;
        op_next    = op_reg;
        pctl_next  = pctl_reg;
        ioctl_next = ioctl_reg;
        // Software first so that hardware updates win the same cycle
        if (bus_wr && hit(wb_adr_i, PCTL_IDX))
            pctl_next = wmerge(pctl_reg, wb_dat_i[15:0],
                               wb_sel_i[1:0], PCTL_WMASK);
        if (bus_wr && hit(wb_adr_i, IOCTL_IDX))
            ioctl_next = wmerge(ioctl_reg, wb_dat_i[15:0],
                                wb_sel_i[1:0], IOCTL_WMASK);
        // Bank field only meaningful while the cassette holds I/O data
        ioctl_next[BANK_HI:BANK_LO] =
            (cart_contents == CONT_IODAT) ? cart_bank : 4'h0;
        unique case (st_reg)
            CTC_IDLE:
            begin
                // Pending bits simply wait while busy
                if (prog_cmd)
                begin
                    pctl_next[B_CK:B_LINK] = '0;
                    if (pctl_reg[B_SAVE])
                    begin
                        op_next = OP_PSAVE;
                        pctl_next[B_SAVE] = 1'b0;
                    end
                    else if (pctl_reg[B_LOAD])
                    begin
                        op_next = OP_PLOAD;
                        pctl_next[B_LOAD] = 1'b0;
                    end
                    else
                    begin
                        op_next = OP_PCMP;
                        pctl_next[B_CMP] = 1'b0;
                    end
                    if (!prog_mode)
                    begin
                        pctl_next[B_MODE] = 1'b1;
                        if (!pctl_reg[B_SAVE] && !pctl_reg[B_LOAD])
                            pctl_next[B_RES] = 1'b1;
                    end
                    else if (pctl_reg[B_SAVE] && link_table_active)
                        pctl_next[B_LINK] = 1'b1;
                    else if (pctl_reg[B_SAVE] && cart_read_only)
                        pctl_next[B_RO] = 1'b1;
                    else if (pctl_reg[B_SAVE] ? !cart_space_ok
                             : (cart_contents != CONT_PROG))
                    begin
                        pctl_next[B_CAP] = 1'b1;
                        if (!pctl_reg[B_SAVE] && !pctl_reg[B_LOAD])
                            pctl_next[B_RES] = 1'b1;
                    end
                    else
                    begin
                        req_next = 1'b1;
                        st_next  = CTC_BUSY;
                    end
                end
                else if (io_cmd)
                begin
                    ioctl_next[B_CAP:B_MODE] = '0;
                    if (ioctl_reg[B_SAVE])
                    begin
                        op_next = OP_ISAVE;
                        ioctl_next[B_SAVE] = 1'b0;
                    end
                    else
                    begin
                        op_next = OP_ILOAD;
                        ioctl_next[B_LOAD] = 1'b0;
                    end
                    if (!prog_mode)
                        ioctl_next[B_MODE] = 1'b1;
                    else if (ioctl_reg[B_SAVE] ? !cart_space_ok
                             : (cart_contents != CONT_IODAT))
                        ioctl_next[B_CAP] = 1'b1;
                    else
                    begin
                        // Read-only is reported but does not stop it
                        ioctl_next[B_RO] = ioctl_reg[B_SAVE]
                                           && cart_read_only;
                        req_next = 1'b1;
                        st_next  = CTC_BUSY;
                    end
                end
            end
            CTC_BUSY:
            begin
                if (xfer_done)
                begin
                    req_next = 1'b0;
                    st_next  = CTC_IDLE;
                    if (op_reg <= OP_PCMP && xfer_cksum_err)
                        pctl_next[B_CK] = 1'b1;
                    if (op_reg == OP_PCMP)
                        pctl_next[B_RES] = xfer_mismatch
                                           || xfer_cksum_err;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_reg    <= CTC_IDLE;
            req_reg   <= 1'b0;
            op_reg    <= OP_PSAVE;
            pctl_reg  <= REG_RST;
            ioctl_reg <= REG_RST;
            size_reg  <= REG_RST;
            merr_reg  <= REG_RST;
            cont_reg  <= CONT_NONE;
            ack_reg   <= 1'b0;
            dat_reg   <= '0;
        end
        else
        begin
            st_reg    <= st_next;
            req_reg   <= req_next;
            op_reg    <= op_next;
            pctl_reg  <= pctl_next;
            ioctl_reg <= ioctl_next;
            size_reg  <= size_next;
            merr_reg  <= merr_next;
            cont_reg  <= cont_next;
            ack_reg   <= ack_next;
            dat_reg   <= dat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign xfer_req = req_reg;
    assign xfer_op  = op_reg;

    default clocking ctc_cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    logic idle_p;
    logic idle_io;
    assign idle_p  = (st_reg == CTC_IDLE) && prog_cmd;
    assign idle_io = (st_reg == CTC_IDLE) && !prog_cmd && io_cmd;

    chk_prog_mode_err: assert property (
        idle_p && !prog_mode |=> pctl_reg[B_MODE] && !xfer_req)
        else $error("program command outside program mode");

    chk_io_mode_err: assert property (
        idle_io && !prog_mode |=> ioctl_reg[B_MODE] && !xfer_req)
        else $error("io command outside program mode");

    chk_save_launch: assert property (
        idle_p && pctl_reg[B_SAVE] && prog_mode && !link_table_active
        && !cart_read_only && cart_space_ok
        |=> xfer_req && xfer_op == OP_PSAVE)
        else $error("program save not launched");

    chk_cmd_self_clear: assert property (
        idle_p && pctl_reg[B_SAVE] |=> !pctl_reg[B_SAVE])
        else $error("save bit not cleared");

    chk_link_blocks: assert property (
        idle_p && pctl_reg[B_SAVE] && prog_mode && link_table_active
        |=> pctl_reg[B_LINK] && !xfer_req)
        else $error("link table error missing");

    chk_ro_io_go: assert property (
        idle_io && ioctl_reg[B_SAVE] && prog_mode && cart_read_only
        && cart_space_ok |=> ioctl_reg[B_RO] && xfer_req)
        else $error("io save with read only mishandled");

    chk_cmp_result: assert property (
        st_reg == CTC_BUSY && op_reg == OP_PCMP && xfer_done
        |=> pctl_reg[B_RES] == ($past(xfer_mismatch)
                                || $past(xfer_cksum_err)))
        else $error("compare result wrong");

    chk_cksum_flag: assert property (
        st_reg == CTC_BUSY && op_reg <= OP_PCMP && xfer_done
        && xfer_cksum_err |=> pctl_reg[B_CK])
        else $error("checksum flag not set");

    chk_one_xfer: assert property (
        xfer_req && !xfer_done |=> xfer_req && $stable(xfer_op))
        else $error("transfer dropped or changed");

    chk_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held over two cycles");

    chk_load_launch: assert property (
        idle_p && !pctl_reg[B_SAVE] && pctl_reg[B_LOAD] && prog_mode
        && cart_contents == CONT_PROG |=> xfer_req && xfer_op == OP_PLOAD)
        else $error("program load not launched");

    chk_cmp_launch: assert property (
        idle_p && !pctl_reg[B_SAVE] && !pctl_reg[B_LOAD] && prog_mode
        && cart_contents == CONT_PROG |=> xfer_req && xfer_op == OP_PCMP)
        else $error("program compare not launched");

    chk_io_save_go: assert property (
        idle_io && ioctl_reg[B_SAVE] && prog_mode && cart_space_ok
        |=> xfer_req && xfer_op == OP_ISAVE)
        else $error("io save not launched");

    chk_io_load_go: assert property (
        idle_io && !ioctl_reg[B_SAVE] && prog_mode
        && cart_contents == CONT_IODAT |=> xfer_req && xfer_op == OP_ILOAD)
        else $error("io load not launched");

    chk_io_self_clear: assert property (
        idle_io && ioctl_reg[B_SAVE] |=> !ioctl_reg[B_SAVE])
        else $error("io save bit not cleared");

    chk_bank_field: assert property (
        1'b1 |=> ioctl_reg[BANK_HI:BANK_LO] ==
        (($past(cart_contents) == CONT_IODAT) ? $past(cart_bank) : 4'h0))
        else $error("bank field wrong");

    chk_size_mirror: assert property (
        1'b1 |=> size_reg == {$past(cpu_prog_size), $past(cart_prog_size)})
        else $error("size word wrong");

    chk_merr_mirror: assert property (
        1'b1 |=> merr_reg == {$past(err_autoboot), $past(err_cart_removed),
        $past(err_vector_cksum), $past(err_ladder_cksum),
        $past(err_setup_cksum), 11'h000})
        else $error("memory error word wrong");

    chk_contents_code: assert property (
        1'b1 |=> cont_reg == $past(cart_contents))
        else $error("contents code wrong");

    cov_save: cover property (xfer_req && xfer_op == OP_PSAVE ##1 xfer_done);
    cov_cmp_diff: cover property (
        op_reg == OP_PCMP && xfer_done && xfer_mismatch);
    cov_io_load: cover property (xfer_req && xfer_op == OP_ILOAD);
    cov_held_cmd: cover property (xfer_req && io_cmd);

endmodule

//--- verif/ctc_cart_model.sv
`timescale 1ns/10ps
module ctc_cart_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       xfer_req,
    input  wire logic [3:0] delay,
    input  wire logic       mis,
    input  wire logic       ck,
    output logic            xfer_done,
    output logic            xfer_mismatch,
    output logic            xfer_cksum_err
);
    logic [4:0] cnt;
    logic       junk;
    // Results only mean something with done; otherwise they wiggle
    always @(posedge sys_clk)
    begin
        junk <= rst ? 1'b0 : ~junk;
        xfer_done <= 1'b0;
        xfer_mismatch <= junk;
        xfer_cksum_err <= ~junk;
        if (rst || xfer_req !== 1'b1)
            cnt <= 5'h00;
        else if (!xfer_done && cnt != {1'b0, delay})
            cnt <= cnt + 5'h01;
        else if (!xfer_done)
        begin
            xfer_done <= 1'b1;
            xfer_mismatch <= mis;
            xfer_cksum_err <= ck;
        end
    end
endmodule

//--- verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import ctc_pkg::*;
    logic        sys_clk, rst, cyc, stb, we, link, ro, space;
    logic        xreq, xreq_d, xdone, xmis, xck, pmis, pck;
    logic [11:0] adr;
    logic [31:0] wdat, rdat;
    logic        ack;
    logic [1:0]  mode, cont;
    logic [3:0]  bank, dly;
    logic [7:0]  csz, psz;
    logic [4:0]  merr;
    logic [2:0]  xop;
    logic [31:0] exp_q[$], msk_q[$];
    logic [2:0]  op_q[$];
    logic [7:0]  codes[5] = '{8'h00, 8'h04, 8'h08, 8'h12, 8'h32};
    int          failures, checks;
    integer      seed = 32'hf5e70dc6;
    ctc_top u_ctc_top (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ctl_mode(mode),
        .link_table_active(link), .cart_read_only(ro),
        .cart_space_ok(space), .cart_contents(cont), .cart_bank(bank),
        .cart_prog_size(csz), .cpu_prog_size(psz),
        .err_setup_cksum(merr[0]), .err_ladder_cksum(merr[1]),
        .err_vector_cksum(merr[2]), .err_cart_removed(merr[3]),
        .err_autoboot(merr[4]), .xfer_req(xreq), .xfer_op(xop),
        .xfer_done(xdone), .xfer_mismatch(xmis), .xfer_cksum_err(xck));
    ctc_cart_model u_ctc_cart_model (.sys_clk(sys_clk), .rst(rst),
        .xfer_req(xreq), .delay(dly), .mis(pmis), .ck(pck),
        .xfer_done(xdone), .xfer_mismatch(xmis), .xfer_cksum_err(xck));
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Monitor: a read ack and the first cycle of a transfer pop the notes
    always @(posedge sys_clk)
    begin
        if (ack === 1'b1 && !we && exp_q.size() > 0)
            chk(rdat & msk_q.pop_front(), exp_q.pop_front());
        if (xreq === 1'b1 && xreq_d !== 1'b1 && op_q.size() > 0)
            chk({29'h0, xop}, {29'h0, op_q.pop_front()});
        xreq_d <= xreq;
    end
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [15:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        // Only the watchdog ends a wait for the answer
        do
        begin
            @(posedge sys_clk);
        end
        while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        bus(1'b0, a, 16'h0000);
    endtask
    task automatic settle;
        int n;
        n = 0;
        while ((op_q.size() > 0 || xreq !== 1'b0) && n < 300)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 300)
            failures++;
    endtask
    // A command, its transfer if any, then the control word read back
    task automatic cmd(input logic [11:0] a, input logic [15:0] d,
                       input logic go, input logic [2:0] op,
                       input logic [15:0] e);
        logic [31:0] m;
        m = (a == 12'h444) ? 32'hff07 : (d[2] ? 32'hf80f : 32'hf807);
        dly <= 4'($unsigned($random(seed)) % 8);
        if (go)
            op_q.push_back(op);
        bus(1'b1, a, d);
        if (!go)
            chk({31'h0, xreq}, 32'h0);
        settle();
        rd(a, {16'h0000, e}, m);
    endtask
    task automatic env(input logic [1:0] m, input logic l, input logic r,
                       input logic s, input logic [1:0] c);
        mode <= m;
        link <= l;
        ro <= r;
        space <= s;
        cont <= c;
    endtask
    initial
    begin
        #100000;
        failures++;
        stop_test();
    end
    initial
    begin
        {rst, cyc, stb, we, pmis, pck, xreq_d} = 7'h41;
        {adr, wdat, dly, merr, csz, psz} = '0;
        {mode, link, ro, space, cont, bank} = 11'h000;
        space = 1'b1;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(12'h438, 32'h0, 32'hffffffff);
        bus(1'b1, 12'h000, 16'hffff);
        rd(12'h000, 32'h0, 32'hffffffff);
        for (int i = 0; i < 6; i++)
        begin
            csz <= codes[$unsigned($random(seed)) % 5];
            psz <= codes[$unsigned($random(seed)) % 5];
            merr <= 5'($random(seed));
            bank <= 4'($random(seed));
            cont <= 2'(i % 3);
            @(posedge sys_clk);
            rd(12'h43c, {16'h0, psz, csz}, 32'hffffffff);
            rd(12'h440, {16'h0, merr, 11'h0}, 32'hffffffff);
            rd(12'h434, {30'h0, cont}, 32'hffffffff);
            rd(12'h444, cont == CONT_IODAT ? {20'h0, bank, 8'h0} : 32'h0,
               32'hf00);
        end
        $display("test reports done");
        env(MODE_PROG, 0, 0, 1, CONT_PROG);
        cmd(12'h438, 16'h1, 1, OP_PSAVE, 16'h0);
        cmd(12'h438, 16'h2, 1, OP_PLOAD, 16'h0);
        pmis <= 1'b1;
        cmd(12'h438, 16'h4, 1, OP_PCMP, 16'h8);
        pmis <= 1'b0;
        cmd(12'h438, 16'h4, 1, OP_PCMP, 16'h0);
        pck <= 1'b1;
        cmd(12'h438, 16'h1, 1, OP_PSAVE, 16'h8000);
        rd(12'h440, {16'h0, merr, 11'h0}, 32'hffffffff);
        pck <= 1'b0;
        cmd(12'h438, 16'h1, 1, OP_PSAVE, 16'h0);
        $display("test program transfers done");
        for (int m = 1; m < 3; m++)
        begin
            mode <= 2'(m);
            cmd(12'h438, 16'h1, 0, 0, 16'h1000);
            cmd(12'h438, 16'h2, 0, 0, 16'h1000);
            cmd(12'h438, 16'h4, 0, 0, 16'h1008);
        end
        env(MODE_PROG, 1, 0, 1, CONT_PROG);
        cmd(12'h438, 16'h1, 0, 0, 16'h0800);
        env(MODE_PROG, 0, 1, 1, CONT_PROG);
        cmd(12'h438, 16'h1, 0, 0, 16'h2000);
        env(MODE_PROG, 0, 0, 0, CONT_PROG);
        cmd(12'h438, 16'h1, 0, 0, 16'h4000);
        env(MODE_PROG, 0, 0, 1, CONT_NONE);
        cmd(12'h438, 16'h2, 0, 0, 16'h4000);
        cmd(12'h438, 16'h4, 0, 0, 16'h4008);
        $display("test program errors done");
        env(MODE_PROG, 0, 0, 1, CONT_IODAT);
        cmd(12'h444, 16'h1, 1, OP_ISAVE, {4'h0, bank, 8'h0});
        cmd(12'h444, 16'h2, 1, OP_ILOAD, {4'h0, bank, 8'h0});
        ro <= 1'b1;
        cmd(12'h444, 16'h1, 1, OP_ISAVE, {4'h2, bank, 8'h0});
        env(MODE_RUN, 0, 0, 1, CONT_IODAT);
        cmd(12'h444, 16'h1, 0, 0, {4'h1, bank, 8'h0});
        cmd(12'h444, 16'h2, 0, 0, {4'h1, bank, 8'h0});
        env(MODE_PROG, 0, 0, 0, CONT_IODAT);
        cmd(12'h444, 16'h1, 0, 0, {4'h4, bank, 8'h0});
        env(MODE_PROG, 0, 0, 1, CONT_PROG);
        cmd(12'h444, 16'h2, 0, 0, 16'h4000);
        $display("test io transfers done");
        op_q.push_back(OP_PSAVE);
        op_q.push_back(OP_PCMP);
        // Long save so the compare is surely written while busy
        dly <= 4'hf;
        bus(1'b1, 12'h438, 16'h1);
        bus(1'b1, 12'h438, 16'h4);
        rd(12'h438, 32'h4, 32'hf807);
        settle();
        rd(12'h438, 32'h0, 32'hf80f);
        $display("test pending command done");
        stop_test();
    end
endmodule
